/* File: core/sdb_device.sv */
// What this block does
// - Read data after cas+posted+parity delays.
// - Write data after column+posted+parity delays.
// - Eight beats for field 00, or 01 with bit high.
// - Field 01, bit low on read or write: chop four.
// - Field 10: always chop four.
// - Latency mode leaves termination timing unchanged.
// - Write timing valid only with loop locked.
// - Controller trains capture or meets worst window.
// - Read then write with checksum: eight or chop.
// - Two-clock preamble: column delay one higher (added by the controller only; this device has no preamble input).
//
// Device end: model of the memory's latency and burst logic.
// Assumes the controller keeps its half of the timing.
//
// Decided for this implementation: the mode, latency and enable settings arrive as plain input ports.
`timescale 1ns/100ps
`default_nettype none
module sdb_device
  import sdb_pkg::*;
#(
  parameter int unsigned DEPTH = MEM_DEPTH
) (
  input  wire logic              clock,
  input  wire logic              reset_n,
  sdb_if.dev                     link,
  input  wire logic [1:0]        mode_reg_zero,
  input  wire logic [LAT_W-1:0]  cas_latency,
  input  wire logic [LAT_W-1:0]  posted_cmd_delay,
  input  wire logic [LAT_W-1:0]  column_write_delay,
  input  wire logic              parity_en,
  input  wire logic              cal_mode_en,
  input  wire logic              crc_en,
  input  wire logic              dll_locked,
  output logic                   burst_is_chop,
  output logic                   term_active,
  output logic                   write_err
);
  import sdb_pkg::*;
  // ----------------------------------------
  // Latency and burst length decode
  // ----------------------------------------
  typedef enum logic [1:0] {
    SDB_ST_IDLE  = 2'b00,
    SDB_ST_WAIT  = 2'b01,
    SDB_ST_BEATS = 2'b10
  } sdb_dev_st_t;
  wire logic [LAT_W-1:0] par_add;
  wire logic [LAT_W-1:0] read_delay_total;
  wire logic [LAT_W-1:0] write_delay_total;
  wire logic             is_rd;
  wire logic             is_wr;
  wire logic             chop_now;
  wire logic [3:0]       beats_now;
  assign par_add           = parity_en ? LAT_W'(PAR_DELAY) : '0;
  assign read_delay_total  = cas_latency + posted_cmd_delay + par_add;
  assign write_delay_total = column_write_delay + posted_cmd_delay + par_add;
  assign is_rd = (link.cmd == SDB_CMD_READ);
  assign is_wr = (link.cmd == SDB_CMD_WRITE);
  // Fixed eight, otf by address bit, fixed chop; unused code treated as eight
  assign chop_now = (mode_reg_zero == BURST_FIXED4) ||
                    ((mode_reg_zero == BURST_OTF) &&
                     !link.burst_select_addr_bit);
  assign beats_now = chop_now ? 4'(BEATS_CHOP) : 4'(BEATS_LONG);
  // ----------------------------------------
  // Burst sequencer
  // ----------------------------------------
  sdb_dev_st_t           st_q;
  logic                  rd_q;
  logic [LAT_W-1:0]      wait_q;
  logic [3:0]            left_q;
  logic [ADDR_W-1:0]     ptr_q;
  logic [DATA_W-1:0]     mem [DEPTH];
  logic [DATA_W-1:0]     dq_q;
  logic                  oe_n_q;
  logic                  dqs_q;
  wire logic             start;
  wire logic             beat;
  assign start = (st_q == SDB_ST_IDLE) && (is_rd || is_wr);
  assign beat  = (st_q == SDB_ST_BEATS);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_q   <= SDB_ST_IDLE;
      rd_q   <= 1'b0;
      wait_q <= '0;
      left_q <= '0;
      ptr_q  <= '0;
      burst_is_chop <= 1'b0;
    end else begin
      case (st_q)
        SDB_ST_IDLE: begin
          if (start) begin
            rd_q   <= is_rd;
            ptr_q  <= link.addr;
            left_q <= beats_now;
            burst_is_chop <= chop_now;
            // Counted from the command edge; read data leaves one clock later via dq_q
            wait_q <= is_rd ? read_delay_total - LAT_W'(2) : write_delay_total - LAT_W'(1);
            st_q   <= SDB_ST_WAIT;
          end
        end
        SDB_ST_WAIT: begin
          if (wait_q <= LAT_W'(1)) begin
            st_q <= SDB_ST_BEATS;
          end else begin
            wait_q <= wait_q - LAT_W'(1);
          end
        end
        SDB_ST_BEATS: begin
          ptr_q  <= ptr_q + ADDR_W'(1);
          left_q <= left_q - 4'(1);
          if (left_q == 4'(1)) begin
            st_q <= SDB_ST_IDLE;
          end
        end
        default: st_q <= SDB_ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // Data path
  // ----------------------------------------
  // Write capture trusts the controller to have trained its window
  always_ff @(posedge clock) begin
    if (beat && !rd_q && !link.dq_ctl_oe_n) begin
      mem[ptr_q] <= link.dq_ctl;
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dq_q   <= '0;
      oe_n_q <= 1'b1;
      dqs_q  <= 1'b0;
      write_err <= 1'b0;
      term_active <= 1'b0;
    end else begin
      dq_q   <= (beat && rd_q) ? mem[ptr_q] : '0;
      oe_n_q <= !(beat && rd_q);
      dqs_q  <= beat && rd_q && !dqs_q;
      // Writes without lock are flagged; timing is not guaranteed then
      write_err <= beat && !rd_q && (!dll_locked || link.dq_ctl_oe_n);
      // Latency mode has no effect here on purpose
      term_active <= link.termination_ctrl;
    end
  end
  assign link.dq_dev      = dq_q;
  assign link.dq_dev_oe_n = oe_n_q;
  assign link.dqs_dev     = dqs_q;
  wire logic unused_ok;
  assign unused_ok = cal_mode_en ^ crc_en;
endmodule
`default_nettype wire

/* File: core/sdb_pkg.sv */
// Shared constants for the burst/latency link between controller and device.
// Assumes single clock, both ends reset by reset_n.
package sdb_pkg;
  // ----------------------------------------
  // Widths and defaults
  // ----------------------------------------
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned LAT_W         = 6;
  localparam int unsigned CL_DEFAULT    = 11;
  localparam int unsigned AL_DEFAULT    = 0;
  localparam int unsigned PAR_DELAY     = 4;
  localparam int unsigned CWL_DEFAULT   = 9;
  localparam int unsigned BEATS_LONG    = 8;
  localparam int unsigned BEATS_CHOP    = 4;
  localparam int unsigned PRE2_CWL_ADD  = 1;
  localparam int unsigned MEM_DEPTH     = 64;
  localparam int unsigned ADDR_W        = 6;
  // ----------------------------------------
  // Burst field encodings
  // ----------------------------------------
  localparam logic [1:0] BURST_FIXED8   = 2'h0;
  localparam logic [1:0] BURST_OTF      = 2'h1;
  localparam logic [1:0] BURST_FIXED4   = 2'h2;
  typedef enum logic [1:0] {
    SDB_CMD_NOP   = 2'b00,
    SDB_CMD_READ  = 2'b01,
    SDB_CMD_WRITE = 2'b10
  } sdb_cmd_t;
endpackage

/* File: core/sdb_if.sv */
// Interface joining the controller end and the device end.
// Assumes one shared clock; each end drives its own data wire (dq_ctl, dq_dev).
`timescale 1ns/100ps
`default_nettype none
interface sdb_if;
  import sdb_pkg::*;
  logic [1:0]        cmd;
  logic [ADDR_W-1:0] addr;
  logic              burst_select_addr_bit;
  logic              termination_ctrl;
  logic [DATA_W-1:0] dq_ctl;
  logic              dq_ctl_oe_n;
  logic              dqs_ctl;
  logic [DATA_W-1:0] dq_dev;
  logic              dq_dev_oe_n;
  logic              dqs_dev;
  modport ctl (output cmd, addr, burst_select_addr_bit, termination_ctrl,
               dq_ctl, dq_ctl_oe_n, dqs_ctl, input dq_dev, dq_dev_oe_n, dqs_dev);
  modport dev (input cmd, addr, burst_select_addr_bit, termination_ctrl,
               dq_ctl, dq_ctl_oe_n, dqs_ctl, output dq_dev, dq_dev_oe_n, dqs_dev);
endinterface
`default_nettype wire

/* File: core/sdb_controller.sv */
// Controller end: issues read/write commands and moves burst data.
// Assumes the device keeps the latency and burst rules.
`timescale 1ns/100ps
`default_nettype none
module sdb_controller
  import sdb_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              reset_n,
  sdb_if.ctl                     link,
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic              req_long,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic [LAT_W-1:0]  cas_latency,
  input  wire logic [LAT_W-1:0]  posted_cmd_delay,
  input  wire logic [LAT_W-1:0]  column_write_delay,
  input  wire logic              parity_en,
  input  wire logic              preamble_two,
  input  wire logic [1:0]        mode_reg_zero,
  input  wire logic              term_req,
  output logic                   busy,
  output logic                   wr_data_take,
  output logic [DATA_W-1:0]      rd_data,
  output logic                   rd_valid
);
  import sdb_pkg::*;
  wire logic [LAT_W-1:0] par_add;
  wire logic [LAT_W-1:0] cwl_eff;
  wire logic [LAT_W-1:0] rl;
  wire logic [LAT_W-1:0] wl;
  wire logic             chop;
  wire logic             go;
  assign par_add = parity_en ? LAT_W'(PAR_DELAY) : '0;
  // Two-clock preamble needs the column delay raised by one
  assign cwl_eff = column_write_delay + (preamble_two ? LAT_W'(PRE2_CWL_ADD) : '0);
  assign rl   = cas_latency + posted_cmd_delay + par_add;
  assign wl   = cwl_eff + posted_cmd_delay + par_add;
  assign chop = (mode_reg_zero == BURST_FIXED4) ||
                ((mode_reg_zero == BURST_OTF) && !req_long);
  assign go   = req_valid && !busy;
  logic [LAT_W-1:0] wait_q;
  logic [3:0]       left_q;
  logic             wr_q;
  logic             beat_q;
  logic [1:0]       cmd_q;
  logic [ADDR_W-1:0] addr_q;
  logic             bsel_q;
  logic [DATA_W-1:0] dq_q;
  logic             oe_n_q;
  logic             dqs_q;
  logic             term_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      busy         <= 1'b0;
      wait_q       <= '0;
      left_q       <= '0;
      wr_q         <= 1'b0;
      beat_q       <= 1'b0;
      cmd_q        <= SDB_CMD_NOP;
      addr_q       <= '0;
      bsel_q       <= 1'b0;
      dq_q         <= '0;
      oe_n_q       <= 1'b1;
      dqs_q        <= 1'b0;
      term_q       <= 1'b0;
      wr_data_take <= 1'b0;
      rd_data      <= '0;
      rd_valid     <= 1'b0;
    end else begin
      cmd_q  <= go ? (req_write ? SDB_CMD_WRITE : SDB_CMD_READ) : SDB_CMD_NOP;
      addr_q <= go ? req_addr : addr_q;
      bsel_q <= go ? req_long : bsel_q;
      // Same termination timing whether or not latency mode is on
      term_q <= term_req;
      rd_valid <= beat_q && !wr_q && !link.dq_dev_oe_n;
      rd_data  <= link.dq_dev;
      if (go) begin
        busy   <= 1'b1;
        wr_q   <= req_write;
        left_q <= chop ? 4'(BEATS_CHOP) : 4'(BEATS_LONG);
        // Command leaves one clock later from cmd_q
        wait_q <= req_write ? wl : rl;
      end else if (busy && !beat_q) begin
        if (wait_q <= LAT_W'(1)) begin
          beat_q <= 1'b1;
        end else begin
          wait_q <= wait_q - LAT_W'(1);
        end
      end else if (beat_q) begin
        left_q <= left_q - 4'(1);
        if (left_q == 4'(1)) begin
          beat_q <= 1'b0;
          busy   <= 1'b0;
        end
      end
      // One pulse per word after the first; the first word must already stand
      wr_data_take <= busy && wr_q && !go &&
                      ((!beat_q && (wait_q <= LAT_W'(2))) ||
                       (beat_q && (left_q > 4'(3))));
      dq_q   <= wr_data;
      oe_n_q <= !(busy && wr_q && !beat_q && wait_q <= LAT_W'(1)) &&
                !(beat_q && wr_q && left_q != 4'(1));
      dqs_q  <= !oe_n_q && !dqs_q;
    end
  end
  assign link.cmd                   = cmd_q;
  assign link.addr                  = addr_q;
  assign link.burst_select_addr_bit = bsel_q;
  assign link.termination_ctrl      = term_q;
  assign link.dq_ctl                = dq_q;
  assign link.dq_ctl_oe_n           = oe_n_q;
  assign link.dqs_ctl               = dqs_q;
endmodule
`default_nettype wire

/* File: test/sdb_link_sva.sv */
// Timing checks on the link between controller and device.
// Assumes the bench holds read 15 and write 13 for the whole run.
`timescale 1ns/100ps
`default_nettype none
module sdb_link_sva #(
  parameter int RL = 15,
  parameter int WL = 13
) (
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic [1:0] cmd,
  input wire logic       dq_ctl_oe_n,
  input wire logic       dq_dev_oe_n
);
  // ----
  // Checks
  // ----
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_read_lat:
    assert property (cmd == 2'h1 |-> ##RL !dq_dev_oe_n) else $error("read data late");
  a_read_early:
    assert property (cmd == 2'h1 |=> dq_dev_oe_n[*8]) else $error("read data early");
  a_write_lat:
    assert property (cmd == 2'h2 |-> ##WL !dq_ctl_oe_n) else $error("write data late");
  a_rd_beats:
    assert property ($fell(dq_dev_oe_n) |-> !dq_dev_oe_n[*4]) else $error("read beats cut");
  a_wr_beats:
    assert property ($fell(dq_ctl_oe_n) |-> !dq_ctl_oe_n[*4]) else $error("write beats cut");
  a_rd_max:
    assert property ($fell(dq_dev_oe_n) |-> ##8 dq_dev_oe_n) else $error("read too long");
  a_wr_max:
    assert property ($fell(dq_ctl_oe_n) |-> ##8 dq_ctl_oe_n) else $error("write too long");
  a_no_clash:
    assert property (!(!dq_ctl_oe_n && !dq_dev_oe_n)) else $error("both ends drive");
endmodule
`default_nettype wire

/* File: test/sdram_latency_burst_select_tb_top.sv */
// Bench: controller and device joined over the link, checked end to end.
// Assumes one 25 MHz clock; parity on, so read 15 and write 13 cycles.
`timescale 1ns/100ps
`default_nettype none
module sdram_latency_burst_select_tb_top;
  import sdb_pkg::*;
  logic              clock, reset_n, req_valid, req_write, req_long;
  logic              parity_en, cal_mode_en, crc_en, dll_locked, term_req;
  logic              busy, wr_data_take, rd_valid, burst_is_chop;
  logic              term_active, write_err, err_seen;
  logic [1:0]        mode_reg_zero;
  logic [ADDR_W-1:0] req_addr;
  logic [DATA_W-1:0] wr_data, rd_data;
  logic [LAT_W-1:0]  cas_latency, posted_cmd_delay, column_write_delay;
  logic [DATA_W-1:0] beats[$];
  int                fail_count, n_compared;
  sdb_if             link ();
  sdb_controller i_sdb_controller (.clock, .reset_n, .link, .req_valid,
    .req_write, .req_long, .req_addr, .wr_data, .cas_latency,
    .posted_cmd_delay, .column_write_delay, .parity_en,
    .preamble_two(1'b0), .mode_reg_zero, .term_req, .busy, .wr_data_take,
    .rd_data, .rd_valid);
  sdb_device i_sdb_device (.clock, .reset_n, .link, .mode_reg_zero,
    .cas_latency, .posted_cmd_delay, .column_write_delay,
    .parity_en, .cal_mode_en, .crc_en, .dll_locked, .burst_is_chop,
    .term_active, .write_err);
  sdb_link_sva #(.RL(15), .WL(13)) u_chk (.clock, .reset_n, .cmd(link.cmd),
    .dq_ctl_oe_n(link.dq_ctl_oe_n), .dq_dev_oe_n(link.dq_dev_oe_n));
  // ----
  // Tasks
  // ----
  task automatic chk8(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(string what, logic exp, logic got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic xfer(logic w, logic l, logic [ADDR_W-1:0] a, logic [7:0] d);
    int n;
    @(posedge clock);
    beats.delete();
    wr_data   <= d;
    req_write <= w;
    req_long  <= l;
    req_addr  <= a;
    req_valid <= 1'b1;
    @(posedge clock);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (busy !== 1'b0 && n < 200);
    if (n >= 200) fail_count++;
    repeat (2) @(posedge clock);
  endtask
  // Beats past n may come from unwritten cells, so only the count is checked
  task automatic check_read(int total, int n, logic [7:0] base);
    chk8("beat count", 8'(total), 8'(beats.size()));
    for (int k = 0; k < n; k++) chk8("read beat", base + 8'(k), beats[k]);
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----
  // Stimulus
  // ----
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    if (rd_valid === 1'b1) beats.push_back(rd_data);
    if (write_err === 1'b1) err_seen <= 1'b1;
    if (wr_data_take === 1'b1) wr_data <= wr_data + 8'h01;
  end
  initial begin
    #400000;
    fail_count++;
    stop_test();
  end
  initial begin
    {reset_n, req_valid, req_write, req_long, cal_mode_en, crc_en} = '0;
    {term_req, err_seen, fail_count, n_compared} = '0;
    {parity_en, dll_locked} = 2'h3;
    cas_latency        = LAT_W'(CL_DEFAULT);
    posted_cmd_delay   = LAT_W'(AL_DEFAULT);
    column_write_delay = LAT_W'(CWL_DEFAULT);
    {mode_reg_zero, req_addr, wr_data} = '0;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    xfer(1'b1, 1'b0, 6'h08, 8'h10);
    xfer(1'b0, 1'b0, 6'h08, 8'h00);
    check_read(8, 8, 8'h10);
    mode_reg_zero <= BURST_OTF;
    xfer(1'b1, 1'b0, 6'h10, 8'h40);
    chk1("chop flag", 1'b1, burst_is_chop);
    xfer(1'b0, 1'b1, 6'h10, 8'h00);
    check_read(8, 4, 8'h40);
    xfer(1'b1, 1'b1, 6'h20, 8'h50);
    chk1("chop flag", 1'b0, burst_is_chop);
    mode_reg_zero <= BURST_FIXED4;
    xfer(1'b0, 1'b1, 6'h20, 8'h00);
    check_read(4, 4, 8'h50);
    chk1("chop flag", 1'b1, burst_is_chop);
    mode_reg_zero <= BURST_OTF;
    crc_en <= 1'b1;
    xfer(1'b0, 1'b1, 6'h08, 8'h00);
    xfer(1'b1, 1'b0, 6'h08, 8'h20);
    xfer(1'b0, 1'b1, 6'h08, 8'h00);
    check_read(8, 4, 8'h20);
    dll_locked <= 1'b0;
    xfer(1'b1, 1'b1, 6'h28, 8'h70);
    chk1("unlocked write error", 1'b1, err_seen);
    dll_locked <= 1'b1;
    err_seen   <= 1'b0;
    xfer(1'b1, 1'b1, 6'h28, 8'h70);
    chk1("locked write error", 1'b0, err_seen);
    cal_mode_en <= 1'b1;
    term_req    <= 1'b1;
    repeat (4) @(posedge clock);
    chk1("termination on", 1'b1, term_active);
    term_req <= 1'b0;
    repeat (4) @(posedge clock);
    chk1("termination off", 1'b0, term_active);
    stop_test();
  end
endmodule
`default_nettype wire
